// ---- src/ifr_top.v ----
`timescale 1ns/10ps
`include "ifr_defs.vh"
module ifr_top (
	input wire clk, // Processor and bus clock, 25 MHz
	input wire arst_n, // Async reset, active low
	input wire fetch_start, // Pulse: start a line fetch
	input wire fetch_cacheable_in, // Attribute of the target line
	input wire noncache_size_bit, // 1: eight-word non-cacheable lines
	output wire fetch_ready, // Idle and return FIFO empty
	output reg fetch_request_q, // Line request to the slave
	output reg fetch_line_size_q, // 1: eight words, 0: four words
	output reg fetch_cacheable_flag_q, // Cacheability of the request
	input wire fetch_addr_ack, // Slave takes the request
	input wire slave_width_flag, // 0: 32-bit, 1: 64-bit slave
	input wire fetch_read_ack, // One transfer on the read bus
	input wire [0:63] fetch_read_bus, // Read data, bit 0 most significant
	input wire [2:0] fetch_word_order, // Word or doubleword position
	output reg line_done_q, // Pulse: whole line received
	output reg order_err_q, // Sticky: invalid order seen
	output reg overrun_q, // Sticky: FIFO full on a transfer
	output reg [7:0] line_valid_q, // Per-instruction received mask
	output reg [255:0] line_data_q, // Fill buffer, instruction 0 low
	output wire ret_valid, // Returned transfer available
	input wire ret_ready, // Consumer takes it
	output wire ret_double, // Entry carries two instructions
	output wire [2:0] ret_index, // Index of first instruction
	output wire [63:0] ret_data // Upper word is first instruction
);
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg width_q;
	reg [3:0] expect_q;
	reg [3:0] count_q;
	reg [3:0] expect_d;
	wire eight_words;
	wire take;
	wire order_bad;
	reg [2:0] idx;
	reg dbl;
	reg [31:0] w_hi;
	reg [31:0] w_lo;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [67:0] fifo_out;
	wire last_xfer;

	// Cacheable lines are always eight words
	assign eight_words = fetch_cacheable_in | noncache_size_bit;

	// New line only when idle and nothing still waits in the FIFO,
	// so a line of up to four transfers fits even with a stalled consumer
	assign fetch_ready = (state_q == `IFR_ST_IDLE) & ~fifo_out_valid;

	// Transfers only count once the line has been acknowledged
	assign take = fetch_read_ack & (state_q == `IFR_ST_DATA);

	// Low order bit set is meaningless for a doubleword slave
	assign order_bad = take & (width_q == `IFR_WIDTH_64) &
		fetch_word_order[0];

	assign last_xfer = take & ((count_q + 4'h1) == expect_q);

	// Expected transfers from width and line size at acknowledge
	always @* begin
		if (slave_width_flag == `IFR_WIDTH_32) begin
			if (fetch_line_size_q)
				expect_d = `IFR_XFER_N32_EIGHT;
			else
				expect_d = `IFR_XFER_N32_FOUR;
		end else begin
			if (fetch_line_size_q)
				expect_d = `IFR_XFER_N64_EIGHT;
			else
				expect_d = `IFR_XFER_N64_FOUR;
		end
	end

	// Placement of the transfer within the line
	always @* begin
		idx = 3'h0;
		dbl = 1'b0;
		w_hi = fetch_read_bus[0:31];
		w_lo = fetch_read_bus[32:63];
		if (width_q == `IFR_WIDTH_32) begin
			// Even orders read bits 0-31, odd ones bits 32-63
			if (fetch_word_order[0])
				w_hi = fetch_read_bus[32:63];
			else
				w_hi = fetch_read_bus[0:31];
			w_lo = w_hi;
			if (fetch_line_size_q)
				idx = fetch_word_order;
			else
				idx = {1'b0, fetch_word_order[1:0]};
		end else begin
			dbl = 1'b1;
			if (fetch_line_size_q)
				idx = {fetch_word_order[2:1], 1'b0};
			else
				idx = {1'b0, fetch_word_order[1], 1'b0};
		end
	end

	// Request, acknowledge and data sequence
	always @* begin
		state_d = state_q;
		case (state_q)
			`IFR_ST_IDLE: begin
				if (fetch_start & fetch_ready)
					state_d = `IFR_ST_REQ;
			end
			`IFR_ST_REQ: begin
				if (fetch_addr_ack)
					state_d = `IFR_ST_DATA;
			end
			`IFR_ST_DATA: begin
				if (last_xfer)
					state_d = `IFR_ST_IDLE;
			end
			default: begin
				state_d = `IFR_ST_IDLE;
			end
		endcase
	end

	// State and request outputs
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= `IFR_ST_IDLE;
			fetch_request_q <= 1'b0;
			fetch_line_size_q <= 1'b0;
			fetch_cacheable_flag_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if ((state_q == `IFR_ST_IDLE) & fetch_start & fetch_ready) begin
				fetch_request_q <= 1'b1;
				fetch_line_size_q <= eight_words;
				fetch_cacheable_flag_q <= fetch_cacheable_in;
			end else if (fetch_addr_ack & (state_q == `IFR_ST_REQ)) begin
				fetch_request_q <= 1'b0;
			end
		end
	end

	// Width flag is only meaningful in the acknowledge cycle, so latch it
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			width_q <= `IFR_WIDTH_32;
			expect_q <= 4'h0;
		end else if (fetch_addr_ack & (state_q == `IFR_ST_REQ)) begin
			width_q <= slave_width_flag;
			expect_q <= expect_d;
		end
	end

	// Transfer counter, one step per acknowledge, any gap allowed
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= 4'h0;
			line_done_q <= 1'b0;
		end else begin
			line_done_q <= last_xfer;
			if (fetch_addr_ack & (state_q == `IFR_ST_REQ))
				count_q <= 4'h0;
			else if (take)
				count_q <= count_q + 4'h1;
		end
	end

	// Sticky error flags, cleared when the next line is requested
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			order_err_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (order_bad)
				order_err_q <= 1'b1;
			else if (state_q == `IFR_ST_REQ)
				order_err_q <= 1'b0;
			if (take & ~fifo_in_ready)
				overrun_q <= 1'b1;
			else if (state_q == `IFR_ST_REQ)
				overrun_q <= 1'b0;
		end
	end

	// Fill buffer, one slot per instruction of the line
	genvar gi;
	generate
		for (gi = 0; gi < `IFR_LINE_WORDS; gi = gi + 1) begin : g_slot
			wire hit_hi;
			wire hit_lo;
			// Doublewords fill the even slot from bits 0-31, odd from 32-63
			assign hit_hi = take & ~order_bad & (idx == gi);
			assign hit_lo = take & ~order_bad & dbl &
				((idx + 3'h1) == gi);
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					line_valid_q[gi] <= 1'b0;
					line_data_q[gi*32 +: 32] <= 32'h00000000;
				end else if (fetch_addr_ack & (state_q == `IFR_ST_REQ)) begin
					line_valid_q[gi] <= 1'b0;
				end else if (hit_hi) begin
					line_valid_q[gi] <= 1'b1;
					line_data_q[gi*32 +: 32] <= w_hi;
				end else if (hit_lo) begin
					line_valid_q[gi] <= 1'b1;
					line_data_q[gi*32 +: 32] <= w_lo;
				end
			end
		end
	endgenerate

	// Every accepted transfer with a valid order also goes out in arrival order;
	// the protocol cannot stall the slave, so a full FIFO only flags
	ifr_fifo #(
		.WIDTH(`IFR_FIFO_W),
		.DEPTH(`IFR_FIFO_DEPTH),
		.AW(`IFR_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(take & ~order_bad),
		.in_ready(fifo_in_ready),
		.in_data({dbl, idx, w_hi, w_lo}),
		.out_valid(fifo_out_valid),
		.out_ready(ret_ready),
		.out_data(fifo_out)
	);

	assign ret_valid = fifo_out_valid;
	assign ret_double = fifo_out[67];
	assign ret_index = fifo_out[66:64];
	assign ret_data = fifo_out[63:0];
endmodule // ifr_top

// ---- src/ifr_defs.vh ----
`ifndef IFR_DEFS_VH
`define IFR_DEFS_VH
// Read bus and instruction geometry
`define IFR_BUS_W 64
`define IFR_INSN_W 32
`define IFR_LINE_WORDS 8
`define IFR_IDX_W 3
`define IFR_CNT_W 4
// Transfer counts per width and line size
`define IFR_XFER_N32_FOUR 4'h4
`define IFR_XFER_N32_EIGHT 4'h8
`define IFR_XFER_N64_FOUR 4'h2
`define IFR_XFER_N64_EIGHT 4'h4
// Width flag encoding
`define IFR_WIDTH_32 1'h0
`define IFR_WIDTH_64 1'h1
// Return FIFO shape
`define IFR_FIFO_DEPTH 4
`define IFR_FIFO_AW 2
`define IFR_FIFO_W 68
// State codes
`define IFR_ST_IDLE 2'h0
`define IFR_ST_REQ 2'h1
`define IFR_ST_DATA 2'h2
`endif

// ---- src/ifr_fifo.v ----
`timescale 1ns/10ps
`include "ifr_defs.vh"
module ifr_fifo #(
	parameter WIDTH = 68,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk, // System clock
	input wire arst_n, // Async reset, active low
	input wire in_valid, // Write request
	output wire in_ready, // Room for a word
	input wire [WIDTH-1:0] in_data, // Write data
	output wire out_valid, // Word available
	input wire out_ready, // Consumer takes word
	output wire [WIDTH-1:0] out_data // Head word
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	// Full and empty come straight from the occupancy count
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	// Pointers and count
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
	// Storage needs no reset; out_valid guards it
	always @(posedge clk) begin
		if (push)
			mem_q[wr_q] <= in_data;
	end
endmodule // ifr_fifo

// ---- tb/ifr_slave_model.sv ----
`timescale 1ns/10ps
module ifr_slave_model (
	input wire clk, // Bus clock
	input wire fetch_request_q, // Line request
	input wire fetch_line_size_q, // Eight words
	input wire wide, // Act as 64-bit
	input wire bad, // Break order or halves
	input wire [1:0] gap, // Idle cycles
	input wire [31:0] seed, // Data base
	output reg fetch_addr_ack, // Request taken
	output reg slave_width_flag, // Bus width
	output reg fetch_read_ack, // Transfer
	output reg [0:63] fetch_read_bus, // Data
	output reg [2:0] fetch_word_order // Position
);
	integer n, k;
	reg sz;
	reg [2:0] w;
	reg [31:0] d;
	// Reverse order, top bit set on four-word lines to prove it is ignored
	initial begin
		{fetch_addr_ack, slave_width_flag, fetch_read_ack} = 3'h0;
		fetch_read_bus = 64'h0;
		fetch_word_order = 3'h0;
		forever begin
			@(negedge clk);
			if (fetch_request_q === 1'h1) begin
				repeat (gap) @(negedge clk);
				sz = fetch_line_size_q;
				n = (sz ? 8 : 4) >> wide;
				fetch_addr_ack = 1'h1;
				slave_width_flag = wide;
				@(negedge clk);
				fetch_addr_ack = 1'h0;
				slave_width_flag = ~wide;
				for (k = 0; k < n; k++) begin
					w = 3'((n - 1 - k) << wide);
					d = seed + w * 32'h01010101;
					fetch_word_order = w | {!sz, 1'h0, bad & wide};
					if (wide)
						fetch_read_bus = {d, d + 32'h01010101};
					else if (bad)
						fetch_read_bus = w[0] ? {~d, d} : {d, ~d};
					else
						fetch_read_bus = {d, d};
					fetch_read_ack = 1'h1;
					@(negedge clk);
					fetch_read_ack = 1'h0;
					fetch_read_bus = ~fetch_read_bus;
					fetch_word_order = ~fetch_word_order;
					repeat (gap) @(negedge clk);
				end
			end
		end
	end
endmodule // ifr_slave_model

// ---- tb/ifr_top_properties.sv ----
`timescale 1ns/10ps
module ifr_props (
	input wire clk, // Clock
	input wire arst_n, // Reset
	input wire fetch_request_q, // Request
	input wire fetch_line_size_q, // Size
	input wire fetch_cacheable_flag_q, // Cacheable
	input wire fetch_addr_ack, // Ack
	input wire slave_width_flag, // Width
	input wire fetch_read_ack, // Transfer
	input wire [0:63] fetch_read_bus, // Data
	input wire [2:0] fetch_word_order, // Order
	input wire line_done_q, // Done
	input wire order_err_q, // Bad order
	input wire [7:0] line_valid_q, // Mask
	input wire [255:0] line_data_q // Fill buffer
);
	logic act, wd, sz;
	logic [3:0] cnt, need;
	logic [2:0] o_q, ix;
	logic [0:63] b_q;
	// Expected count and slot; width is only valid on the ack cycle
	assign need = wd ? (sz ? 4'h4 : 4'h2) : (sz ? 4'h8 : 4'h4);
	assign ix = {o_q[2] & sz, o_q[1], o_q[0] & !wd};
	// Track the line in flight
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{act, wd, sz, cnt, o_q, b_q} <= 74'h0;
		end else begin
			b_q <= fetch_read_bus;
			o_q <= fetch_word_order;
			if (fetch_addr_ack && fetch_request_q) begin
				{act, wd, sz, cnt} <= {1'h1, slave_width_flag,
					fetch_line_size_q, 4'h0};
			end else if (act && fetch_read_ack) begin
				cnt <= cnt + 4'h1;
				act <= cnt != need - 4'h1;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Request size, order errors, fill buffer placement and completion
	property p_size;
		fetch_request_q && fetch_cacheable_flag_q |-> fetch_line_size_q;
	endproperty
	a_size: assert property (p_size) else $error("size");
	property p_done;
		act && fetch_read_ack && cnt == need - 4'h1 |=> line_done_q;
	endproperty
	a_done: assert property (p_done) else $error("done");
	property p_dsrc;
		line_done_q |-> $past(fetch_read_ack) && !act;
	endproperty
	a_dsrc: assert property (p_dsrc) else $error("early done");
	property p_oerr;
		act && wd && fetch_read_ack && fetch_word_order[0] |=> order_err_q;
	endproperty
	a_oerr: assert property (p_oerr) else $error("order err");
	property p_esrc;
		$rose(order_err_q) |-> $past(fetch_read_ack) && $past(act);
	endproperty
	a_esrc: assert property (p_esrc) else $error("err src");
	property p_d32;
		act && !wd && fetch_read_ack |=> line_data_q[{ix, 5'h0} +: 32]
			== (o_q[0] ? b_q[32:63] : b_q[0:31]);
	endproperty
	a_d32: assert property (p_d32) else $error("word");
	property p_d64;
		act && wd && fetch_read_ack && !fetch_word_order[0]
			|=> line_data_q[{ix, 5'h0} +: 64] == {b_q[32:63], b_q[0:31]};
	endproperty
	a_d64: assert property (p_d64) else $error("pair");
	property p_hold;
		!fetch_read_ack && !fetch_addr_ack |=> $stable(line_valid_q);
	endproperty
	a_hold: assert property (p_hold) else $error("mask moved");
endmodule // ifr_props
bind ifr_top ifr_props u_props (.clk, .arst_n, .fetch_request_q,
	.fetch_line_size_q, .fetch_cacheable_flag_q, .fetch_addr_ack,
	.slave_width_flag, .fetch_read_ack, .fetch_read_bus, .fetch_word_order,
	.line_done_q, .order_err_q, .line_valid_q, .line_data_q);

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic clk, arst_n, fetch_start, fetch_cacheable_in, noncache_size_bit;
	logic ret_ready, wide, bad, stall;
	logic [1:0] gap;
	logic [7:0] ev;
	logic [31:0] seed, r, lfsr, x;
	wire fetch_ready, fetch_request_q, fetch_line_size_q;
	wire fetch_cacheable_flag_q, fetch_addr_ack, slave_width_flag;
	wire fetch_read_ack, line_done_q, order_err_q, overrun_q;
	wire ret_valid, ret_double;
	wire [0:63] fetch_read_bus;
	wire [2:0] fetch_word_order, ret_index;
	wire [7:0] line_valid_q;
	wire [255:0] line_data_q;
	wire [63:0] ret_data;
	integer err_total, total_checks, i;
	ifr_top dut_u (.clk, .arst_n, .fetch_start, .fetch_cacheable_in,
		.noncache_size_bit, .fetch_ready, .fetch_request_q,
		.fetch_line_size_q, .fetch_cacheable_flag_q, .fetch_addr_ack,
		.slave_width_flag, .fetch_read_ack, .fetch_read_bus,
		.fetch_word_order, .line_done_q, .order_err_q, .overrun_q,
		.line_valid_q, .line_data_q, .ret_valid, .ret_ready, .ret_double,
		.ret_index, .ret_data);
	ifr_slave_model sm_u (.clk, .fetch_request_q, .fetch_line_size_q,
		.wide, .bad, .gap, .seed, .fetch_addr_ack, .slave_width_flag,
		.fetch_read_ack, .fetch_read_bus, .fetch_word_order);
	// Maximal-length taps, so gaps and data never lock into a short loop
	function automatic [31:0] nxt(input [31:0] v);
		nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic [31:0] ins(input [2:0] k);
		ins = seed + k * 32'h01010101;
	endfunction
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'h1) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	// Random pops keep the return buffer under pressure; the entry
	// checked is the one the next rising edge really pops
	always @(negedge clk) begin
		lfsr = nxt(lfsr);
		ret_ready = !stall && lfsr[0];
		if (ret_valid === 1'h1 && ret_ready === 1'h1) begin
			x = ins(ret_index + {2'h0, wide});
			chk(ret_data[63:32] === ins(ret_index), "ret hi");
			chk({ret_double, ret_data[31:0]} === {wide, x}, "ret lo");
		end
	end
	// One line fetch; bad order is only reported, never stored
	task run(input logic w, c, s, b, st);
		integer t, k;
		r = nxt(r);
		{wide, bad, stall, gap, seed} = {w, b, st, r[1:0], r};
		{fetch_cacheable_in, noncache_size_bit, fetch_start} = {c, s, 1'h1};
		@(negedge clk);
		fetch_start = 1'h0;
		chk({fetch_request_q, fetch_line_size_q, fetch_cacheable_flag_q}
			=== {1'h1, c | s, c}, "req");
		ev = w & b ? 8'h00 : {{4{c | s}}, 4'hF};
		t = 0;
		while (line_done_q !== 1'h1 && t < 200) begin
			@(negedge clk);
			t++;
		end
		chk(t < 200 && line_valid_q === ev, "mask");
		for (k = 0; k < 8; k++)
			if (ev[k])
				chk(line_data_q[k * 32 +: 32] === ins(k[2:0]), "data");
		chk(order_err_q === (w & b), "order");
		if (st)
			chk(overrun_q === 1'h1, "overrun");
		stall = 1'h0;
		while (fetch_ready !== 1'h1 && t < 400) begin
			@(negedge clk);
			t++;
		end
		chk(t < 400, "drain");
	endtask
	initial begin
		{err_total, total_checks} = 0;
		r = 32'hA2ACEB7F;
		lfsr = r;
		{arst_n, fetch_start, fetch_cacheable_in, noncache_size_bit} = 4'h0;
		{wide, bad, stall, gap, seed, ret_ready} = 38'h0;
		repeat (12) @(negedge clk);
		arst_n = 1'h1;
		for (i = 0; i < 8; i++)
			run(i[2], i[1], i[0], 1'h0, 1'h0);
		run(1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
		run(1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
		run(1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
		repeat (12) begin
			r = nxt(r);
			run(r[5], r[6], r[7], 1'h0, 1'h0);
		end
		stop_test;
	end
	// Cut a hang short
	initial begin
		#400000;
		err_total++;
		$display("MISMATCH %0t timeout", $time);
		stop_test;
	end
endmodule // tb_top
